// ==== nov_consts.svh ====
// Constants of the neutral overvoltage stage: offsets, fields, resets, timing.
// Included by the stage, the comparator and the testbench; holds definitions only.
`ifndef NOV_CONSTS_SVH
`define NOV_CONSTS_SVH
`define NOV_CLK_NS          5
`define NOV_TIME_BASE_NS    5000000
`define NOV_TICK_CYCLES     (`NOV_TIME_BASE_NS / `NOV_CLK_NS)
`define NOV_OFS_CTRL        8'h00
`define NOV_OFS_VT_NOM      8'h04
`define NOV_OFS_GRP0        8'h20
`define NOV_OFS_GRP1        8'h30
`define NOV_OFS_STATUS      8'h40
`define NOV_OFS_PICKUP_PRI  8'h44
`define NOV_OFS_EXPECTED    8'h48
`define NOV_OFS_REMAINING   8'h4C
`define NOV_OFS_RATIO       8'h50
`define NOV_GRP_THR         2'h0
`define NOV_GRP_DELAY       2'h1
`define NOV_GRP_DIAL        2'h2
`define NOV_GRP_EXP         2'h3
`define NOV_CTRL_SEL_LSB    0
`define NOV_CTRL_FORCE_LSB  2
`define NOV_CTRL_INVERSE_TIME_MODE_BIT   4
`define NOV_CTRL_GROUP_BIT  5
`define NOV_THR_MIN         14'h0064
`define NOV_THR_MAX         14'h26AC
`define NOV_THR_RST         14'h07D0
`define NOV_DELAY_RST       19'h00008
`define NOV_DELAY_MAX       19'h57E40
`define NOV_DIAL_RST        13'h0005
`define NOV_EXP_RST         12'h064
`define NOV_EXP_UNIT        12'h064
`define NOV_VT_NOM_RST      24'h0003E8
`define NOV_PCT_SCALE       40'h000001BB5E
`define NOV_THIRD_SCALE     40'h0000005556
`define NOV_PCT_PER_CENT    40'h0000000064
`define NOV_RATIO_MAX       32'h0001E848
`define NOV_CENTI_SCALE     64'h0000000000068DB9
`define NOV_HYST_NUM        24'h000061
`define NOV_HYST_DEN        24'h000064
`define NOV_ONE_Q16         40'h0000010000
`define NOV_PWR_CAP         40'h00FFFFFFFF
`define NOV_TIME_NUM_SHIFT  17
`endif

// ==== nov_pkg.sv ====
// Types shared by the neutral overvoltage stage modules.
// Assumes nothing beyond a SystemVerilog compiler.
package nov_pkg;
  typedef enum logic [1:0] {NOV_SEL_NONE, NOV_SEL_CALC, NOV_SEL_CH3, NOV_SEL_CH4} nov_sel_e;
  typedef enum logic [1:0] {NOV_SRC_NONE, NOV_SRC_CALC, NOV_SRC_CH3, NOV_SRC_CH4} nov_src_e;
  typedef enum logic [1:0] {NOV_FORCE_NORMAL, NOV_FORCE_START, NOV_FORCE_TRIP,
                            NOV_FORCE_BLOCKED} nov_force_e;
  typedef logic [39:0] nov_word_t;
endpackage

// ==== nov_div_if.sv ====
// Request and answer of the shared sequential divider.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface nov_div_if;
  import nov_pkg::*;
  logic      go;
  nov_word_t dividend;
  nov_word_t divisor;
  logic      done;
  nov_word_t quotient;
  modport requester (output go, output dividend, output divisor, input done, input quotient);
  modport divider   (input go, input dividend, input divisor, output done, output quotient);
endinterface
`default_nettype wire

// ==== nov_div.sv ====
// Shift-subtract unsigned divider, one quotient bit per clock.
// Assumes go is a pulse while idle; divide by zero yields all ones.
`timescale 1ns/1ps
`default_nettype none
module nov_div
  import nov_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  nov_div_if.divider div
);
  nov_word_t rem, next_rem, quo, next_quo, dsr, next_dsr;
  logic [5:0] cnt, next_cnt;
  logic       busy, next_busy, done, next_done;
  logic [40:0] trial;

  always_comb begin
    next_rem  = rem;
    next_quo  = quo;
    next_dsr  = dsr;
    next_cnt  = cnt;
    next_busy = busy;
    next_done = 1'b0;
    trial     = {rem, quo[39]};
    if (!busy && div.go) begin
      next_rem  = '0;
      next_quo  = div.dividend;
      next_dsr  = div.divisor;
      next_cnt  = 6'h28;
      next_busy = 1'b1;
    end else if (busy) begin
      if (trial >= {1'b0, dsr}) begin
        next_rem = 40'(trial - {1'b0, dsr});
        next_quo = {quo[38:0], 1'b1};
      end else begin
        next_rem = trial[39:0];
        next_quo = {quo[38:0], 1'b0};
      end
      next_cnt = cnt - 6'h01;
      if (cnt == 6'h01) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rem  <= '0;
      quo  <= '0;
      dsr  <= '0;
      cnt  <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      rem  <= next_rem;
      quo  <= next_quo;
      dsr  <= next_dsr;
      cnt  <= next_cnt;
      busy <= next_busy;
      done <= next_done;
    end
  end

  assign div.done     = done;
  assign div.quotient = quo;
endmodule // nov_div
`default_nettype wire

// ==== nov_cmp.sv ====
// Pick-up comparator with fixed release hysteresis against the threshold.
// Assumes en pulses once per measurement update.
`timescale 1ns/1ps
`default_nettype none
`include "nov_consts.svh"
module nov_cmp
  import nov_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        en,
  input  wire logic        valid,
  input  wire logic [16:0] level,
  input  wire logic [13:0] thr,
  output logic             pickup
);
  logic        next_pickup;
  logic [40:0] lhs, rhs;

  always_comb begin
    lhs         = 41'(level) * 41'(`NOV_HYST_DEN);
    rhs         = 41'(thr) * 41'(`NOV_HYST_NUM);
    next_pickup = pickup;
    if (en) begin
      if (!valid)
        next_pickup = 1'b0;
      else if (level > 17'(thr))
        next_pickup = 1'b1; // RQ7
      else if (lhs < rhs)
        next_pickup = 1'b0; // RQ8
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst)
      pickup <= 1'b0;
    else
      pickup <= next_pickup;
  end
endmodule // nov_cmp
`default_nettype wire

// ==== nov_stage.sv ====
// Neutral overvoltage stage: source choice, pick-up, timing, status, registers.
// Assumes magnitudes in 0.01 V secondary, refreshed by meas_strobe; classic Wishbone.
// Overview of operation
// RQ1 - Calculated residual is third of phase sum
// RQ2 - Scale residual so 57.74 V is 100 percent
// RQ3 - Front end refreshes RMS magnitudes every 5 ms
// RQ4 - Four input selections, none chosen by default
// RQ5 - Channels three, four need residual mode
// RQ6 - Forced status only under global forcing permission
// RQ7 - Pick up when magnitude exceeds threshold
// RQ8 - Release below 97 percent of threshold
// RQ9 - Threshold 1.00 to 99.00 percent, default 20
// RQ10 - Selection and forcing are static, not grouped
// RQ11 - Active group switches operating parameters live
// RQ12 - No selection falls back to calculated residual
// RQ13 - Report unavailable residual when none exists
// RQ14 - Report expected time, recomputed in inverse mode
// RQ15 - Report signed time remaining to trip
// RQ16 - Report measured to threshold ratio
// RQ17 - Report primary pick-up level in 0.1 V
// RQ18 - Fixed delay trips after delay, zero instant
// RQ19 - Inverse time is dial over ratio power minus one
// RQ20 - Block at pick-up gives blocked, not start
// RQ21 - Compare once per measurement update
//
// Decided for this implementation: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "nov_consts.svh"
module nov_stage
  import nov_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `NOV_TICK_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [15:0] residual_voltage,
  input  wire logic [15:0] third_voltage_channel,
  input  wire logic [15:0] fourth_voltage_channel,
  input  wire logic [15:0] phase1_voltage,
  input  wire logic [15:0] phase2_voltage,
  input  wire logic [15:0] phase3_voltage,
  input  wire logic        meas_strobe,
  input  wire logic        line_neutral_connected,
  input  wire logic        third_residual_mode,
  input  wire logic        fourth_residual_mode,
  input  wire logic        stage_forcing_enable,
  input  wire logic        block_in,
  output logic             pickup,
  output logic             stage_start,
  output logic             stage_trip,
  output logic             stage_blocked
);
  typedef enum {ST_IDLE, ST_RATIO, ST_POWER, ST_TIME} nov_calc_e;

  nov_div_if div ();

  // Register file
  logic [7:0]  ctrl, next_ctrl;
  logic [23:0] vt_nom, next_vt_nom;
  logic [13:0] thr_g [2];
  logic [13:0] next_thr_g [2];
  logic [18:0] delay_g [2];
  logic [18:0] next_delay_g [2];
  logic [12:0] dial_g [2];
  logic [12:0] next_dial_g [2];
  logic [11:0] exp_g [2];
  logic [11:0] next_exp_g [2];
  logic [31:0] rd_data, next_rd_data;
  logic        ack, next_ack;
  logic        wr_en, grp_hit;
  logic        gi;

  // Measurement and timing state
  logic [16:0] level, next_level;
  nov_src_e    src;
  logic        upd, next_upd;
  logic [31:0] tick_cnt, next_tick_cnt;
  logic        tick;
  nov_calc_e   cst, next_cst;
  nov_word_t   rq, next_rq, pw, next_pw;
  logic [4:0]  pw_left, next_pw_left;
  logic [18:0] inverse_time_mode_t, next_inverse_time_mode_t;
  logic [31:0] ratio, next_ratio;
  logic        pick_d, next_pick_d;
  logic        st_start, next_st_start, st_trip, next_st_trip;
  logic        st_blk, next_st_blk;
  logic [18:0] elapsed, next_elapsed;
  logic [18:0] expected;
  logic [19:0] remaining;
  logic [31:0] pickup_pri;
  logic [63:0] pri_prod;
  logic [40:0] sum3;
  logic [79:0] pw_prod;
  logic [4:0]  exp_int;
  nov_sel_e    sel;
  nov_force_e  force_st;
  logic [2:0]  pad;

  assign sel      = nov_sel_e'(ctrl[`NOV_CTRL_SEL_LSB +: 2]); // RQ10
  assign force_st = nov_force_e'(ctrl[`NOV_CTRL_FORCE_LSB +: 2]); // RQ10
  assign gi       = ctrl[`NOV_CTRL_GROUP_BIT]; // RQ11
  assign wr_en    = wb_cyc_i && wb_stb_i && wb_we_i && !ack;
  assign grp_hit  = (wb_adr_i[7:4] == 4'(`NOV_OFS_GRP0 >> 4))
                 || (wb_adr_i[7:4] == 4'(`NOV_OFS_GRP1 >> 4));

  // Source resolution
  always_comb begin
    src = NOV_SRC_NONE;
    case (sel)
      NOV_SEL_NONE: src = line_neutral_connected ? NOV_SRC_CALC : NOV_SRC_NONE; // RQ12 RQ13
      NOV_SEL_CALC: src = NOV_SRC_CALC; // RQ4
      NOV_SEL_CH3:  src = third_residual_mode ? NOV_SRC_CH3 : NOV_SRC_NONE; // RQ5
      NOV_SEL_CH4:  src = fourth_residual_mode ? NOV_SRC_CH4 : NOV_SRC_NONE; // RQ5
      default:      src = NOV_SRC_NONE;
    endcase
  end

  // Level in 0.01 percent of nominal, latched at each update
  always_comb begin
    sum3       = 41'(phase1_voltage) + 41'(phase2_voltage) + 41'(phase3_voltage);
    next_level = level;
    next_upd   = meas_strobe; // RQ21
    if (meas_strobe) begin
      case (src)
        NOV_SRC_CALC: next_level = 17'(((((sum3 * `NOV_THIRD_SCALE) >> 16)
                                        * `NOV_PCT_SCALE) >> 16)); // RQ1 RQ2
        NOV_SRC_CH3:  next_level = 17'((41'(third_voltage_channel) * `NOV_PCT_SCALE) >> 16); // RQ2
        NOV_SRC_CH4:  next_level = 17'((41'(fourth_voltage_channel) * `NOV_PCT_SCALE) >> 16); // RQ2
        default:      next_level = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      level <= '0;
      upd   <= 1'b0;
    end else begin
      level <= next_level;
      upd   <= next_upd;
    end
  end

  nov_cmp u_cmp (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .en      (upd),
    .valid   (src != NOV_SRC_NONE),
    .level   (level),
    .thr     (thr_g[gi]),
    .pickup  (pickup)
  );

  nov_div u_div (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .div     (div.divider)
  );

  // Ratio and inverse time computation after each update
  always_comb begin
    exp_int      = (exp_g[gi] / `NOV_EXP_UNIT) == 12'h000 ? 5'h01
                 : 5'(exp_g[gi] / `NOV_EXP_UNIT);
    pw_prod      = 80'(pw) * 80'(rq);
    next_cst     = cst;
    next_rq      = rq;
    next_pw      = pw;
    next_pw_left = pw_left;
    next_inverse_time_mode_t  = inverse_time_mode_t;
    next_ratio   = ratio;
    div.go       = 1'b0;
    div.dividend = 40'(level) << 16;
    div.divisor  = 40'(thr_g[gi]);
    case (cst)
      ST_IDLE: if (upd) begin
        div.go   = 1'b1;
        next_cst = ST_RATIO;
      end
      ST_RATIO: if (div.done) begin
        next_rq      = div.quotient;
        next_pw      = div.quotient;
        next_pw_left = exp_int - 5'h01;
        next_ratio   = ((div.quotient * `NOV_PCT_PER_CENT) >> 16) > 40'(`NOV_RATIO_MAX)
                     ? `NOV_RATIO_MAX : 32'((div.quotient * `NOV_PCT_PER_CENT) >> 16); // RQ16
        next_cst     = ST_POWER;
      end
      ST_POWER: if (pw_left != 5'h00) begin
        next_pw      = (pw_prod >> 16) > 80'(`NOV_PWR_CAP) ? `NOV_PWR_CAP : 40'(pw_prod >> 16);
        next_pw_left = pw_left - 5'h01;
      end else if (pw <= `NOV_ONE_Q16) begin
        next_inverse_time_mode_t = `NOV_DELAY_MAX;
        next_cst    = ST_IDLE;
      end else begin
        div.go       = 1'b1;
        div.dividend = 40'(dial_g[gi]) << `NOV_TIME_NUM_SHIFT; // RQ19
        div.divisor  = pw - `NOV_ONE_Q16; // RQ19
        next_cst     = ST_TIME;
      end
      ST_TIME: if (div.done) begin
        next_inverse_time_mode_t = div.quotient > 40'(`NOV_DELAY_MAX) ? `NOV_DELAY_MAX
                    : 19'(div.quotient); // RQ14
        next_cst    = ST_IDLE;
      end
      default: next_cst = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cst     <= ST_IDLE;
      rq      <= '0;
      pw      <= '0;
      pw_left <= '0;
      inverse_time_mode_t  <= `NOV_DELAY_MAX;
      ratio   <= '0;
    end else begin
      cst     <= next_cst;
      rq      <= next_rq;
      pw      <= next_pw;
      pw_left <= next_pw_left;
      inverse_time_mode_t  <= next_inverse_time_mode_t;
      ratio   <= next_ratio;
    end
  end

  // Start, trip and blocked sequencing
  assign expected  = ctrl[`NOV_CTRL_INVERSE_TIME_MODE_BIT] ? inverse_time_mode_t : delay_g[gi]; // RQ14
  assign remaining = 20'(expected) - 20'(elapsed); // RQ15
  assign tick      = (tick_cnt == TICK_CYCLES - 1);

  always_comb begin
    next_tick_cnt = tick ? '0 : tick_cnt + 32'h00000001;
    next_pick_d   = pickup;
    next_st_start = st_start;
    next_st_blk   = st_blk;
    next_elapsed  = elapsed;
    if (!pickup) begin
      next_st_start = 1'b0;
      next_st_blk   = 1'b0;
      next_elapsed  = '0;
    end else if (!pick_d) begin
      next_st_start = !block_in; // RQ20
      next_st_blk   = block_in; // RQ20
    end else if (st_start && block_in) begin
      next_st_start = 1'b0; // RQ20
      next_st_blk   = 1'b1;
      next_elapsed  = '0;
    end else if (st_start && tick && elapsed < `NOV_DELAY_MAX) begin
      next_elapsed = elapsed + 19'h00001;
    end
    next_st_trip = next_st_start && (next_elapsed >= expected); // RQ18
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tick_cnt <= '0;
      pick_d   <= 1'b0;
      st_start <= 1'b0;
      st_trip  <= 1'b0;
      st_blk   <= 1'b0;
      elapsed  <= '0;
    end else begin
      tick_cnt <= next_tick_cnt;
      pick_d   <= next_pick_d;
      st_start <= next_st_start;
      st_trip  <= next_st_trip;
      st_blk   <= next_st_blk;
      elapsed  <= next_elapsed;
    end
  end

  always_comb begin
    stage_start   = st_start;
    stage_trip    = st_trip;
    stage_blocked = st_blk;
    if (stage_forcing_enable) begin
      stage_start   = (force_st == NOV_FORCE_START) || (force_st == NOV_FORCE_TRIP)
                    || (force_st == NOV_FORCE_NORMAL && st_start); // RQ6
      stage_trip    = (force_st == NOV_FORCE_TRIP) || (force_st == NOV_FORCE_NORMAL && st_trip);
      stage_blocked = (force_st == NOV_FORCE_BLOCKED) || (force_st == NOV_FORCE_NORMAL && st_blk);
    end
  end

  assign pri_prod   = 64'(thr_g[gi]) * 64'(vt_nom) * `NOV_CENTI_SCALE;
  assign pickup_pri = src == NOV_SRC_NONE ? 32'h00000000 : 32'(pri_prod >> 32); // RQ17

  // Wishbone slave, answers one cycle after the request
  always_comb begin
    next_ctrl    = ctrl;
    next_vt_nom  = vt_nom;
    next_thr_g   = thr_g;
    next_delay_g = delay_g;
    next_dial_g  = dial_g;
    next_exp_g   = exp_g;
    next_ack     = wb_cyc_i && wb_stb_i && !ack;
    next_rd_data = 32'h00000000;
    pad          = 3'h0;
    if (wr_en && wb_sel_i[0] && wb_adr_i == `NOV_OFS_CTRL)
      next_ctrl = {2'h0, wb_dat_i[5:0]};
    if (wr_en && wb_adr_i == `NOV_OFS_VT_NOM) begin
      if (wb_sel_i[0]) next_vt_nom[7:0] = wb_dat_i[7:0];
      if (wb_sel_i[1]) next_vt_nom[15:8] = wb_dat_i[15:8];
      if (wb_sel_i[2]) next_vt_nom[23:16] = wb_dat_i[23:16];
    end
    if (wr_en && grp_hit && wb_sel_i[0]) begin
      case (wb_adr_i[3:2])
        `NOV_GRP_THR:
          if (wb_dat_i[13:0] >= `NOV_THR_MIN && wb_dat_i[13:0] <= `NOV_THR_MAX
              && wb_dat_i[31:14] == 18'h00000)
            next_thr_g[wb_adr_i[4]] = wb_dat_i[13:0]; // RQ9
        `NOV_GRP_DELAY:
          if (wb_dat_i[18:0] <= `NOV_DELAY_MAX) next_delay_g[wb_adr_i[4]] = wb_dat_i[18:0];
        `NOV_GRP_DIAL: next_dial_g[wb_adr_i[4]] = wb_dat_i[12:0];
        `NOV_GRP_EXP:  next_exp_g[wb_adr_i[4]] = wb_dat_i[11:0];
        default:       pad = 3'h0;
      endcase
    end
    if (wb_cyc_i && wb_stb_i && !wb_we_i) begin
      if (grp_hit) begin
        case (wb_adr_i[3:2])
          `NOV_GRP_THR:   next_rd_data = 32'(thr_g[wb_adr_i[4]]);
          `NOV_GRP_DELAY: next_rd_data = 32'(delay_g[wb_adr_i[4]]);
          `NOV_GRP_DIAL:  next_rd_data = 32'(dial_g[wb_adr_i[4]]);
          default:        next_rd_data = 32'(exp_g[wb_adr_i[4]]);
        endcase
      end else begin
        case (wb_adr_i)
          `NOV_OFS_CTRL:       next_rd_data = 32'(ctrl);
          `NOV_OFS_VT_NOM:     next_rd_data = 32'(vt_nom);
          `NOV_OFS_STATUS:     next_rd_data = 32'({pickup, stage_blocked, stage_trip,
                                                   stage_start, src}); // RQ12 RQ13
          `NOV_OFS_PICKUP_PRI: next_rd_data = pickup_pri; // RQ17
          `NOV_OFS_EXPECTED:   next_rd_data = 32'(expected); // RQ14
          `NOV_OFS_REMAINING:  next_rd_data = {{12{remaining[19]}}, remaining}; // RQ15
          `NOV_OFS_RATIO:      next_rd_data = ratio; // RQ16
          default:             next_rd_data = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl     <= 8'h00;
      vt_nom   <= `NOV_VT_NOM_RST;
      thr_g    <= '{`NOV_THR_RST, `NOV_THR_RST};
      delay_g  <= '{`NOV_DELAY_RST, `NOV_DELAY_RST};
      dial_g   <= '{`NOV_DIAL_RST, `NOV_DIAL_RST};
      exp_g    <= '{`NOV_EXP_RST, `NOV_EXP_RST};
      ack      <= 1'b0;
      rd_data  <= '0;
    end else begin
      ctrl     <= next_ctrl;
      vt_nom   <= next_vt_nom;
      thr_g    <= next_thr_g;
      delay_g  <= next_delay_g;
      dial_g   <= next_dial_g;
      exp_g    <= next_exp_g;
      ack      <= next_ack;
      rd_data  <= next_rd_data;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rd_data;
endmodule // nov_stage
`default_nettype wire

// ==== nov_stage_asserts.sv ====
// Port checker of the neutral overvoltage stage.
// Bound to nov_stage; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module nov_stage_chk (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        meas_strobe,
  input wire logic        stage_forcing_enable,
  input wire logic        pickup,
  input wire logic        stage_start,
  input wire logic        stage_trip,
  input wire logic        stage_blocked
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_cause_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  write_data_a: assert property (wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0)
    else $error("write ack data not zero");
  pickup_update_a: assert property ($changed(pickup) |-> $past(meas_strobe, 2))
    else $error("pickup moved off update");
  start_cause_a: assert property ($rose(stage_start) && !stage_forcing_enable
    && !$past(stage_forcing_enable) |-> $past(pickup)) else $error("start without pickup");
  start_block_a: assert property (!stage_forcing_enable |-> !(stage_start && stage_blocked))
    else $error("start with blocked");
  trip_start_a: assert property (stage_trip && !stage_forcing_enable |-> stage_start)
    else $error("trip without start");
endmodule // nov_stage_chk
bind nov_stage nov_stage_chk u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .meas_strobe(meas_strobe), .stage_forcing_enable(stage_forcing_enable),
  .pickup(pickup), .stage_start(stage_start), .stage_trip(stage_trip),
  .stage_blocked(stage_blocked)
);
`default_nettype wire

// ==== nov_front.sv ====
// Measurement front end model: magnitudes with refresh strobe.
// Values valid only in the strobe cycle, inverted otherwise.
`timescale 1ns/1ps
`default_nettype none
module nov_front #(
  parameter int PERIOD = 1250
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic [15:0] want [6],
  output logic [15:0]      mag [6],
  output logic             meas_strobe
);
  int cnt;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt <= 0;
      meas_strobe <= 1'b0;
      mag <= '{default: 16'h0000};
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      meas_strobe <= (cnt == PERIOD - 1);
      for (int i = 0; i < 6; i++) begin
        mag[i] <= (cnt == PERIOD - 1) ? want[i] : ~want[i];
      end
    end
  end
endmodule // nov_front
`default_nettype wire

// ==== tb_neutral_overvoltage_pickup.sv ====
// Testbench of the neutral overvoltage stage.
// Uses nov_front as measurement source and Wishbone tasks.
`timescale 1ns/1ps
`default_nettype none
`include "nov_consts.svh"
module tb_neutral_overvoltage_pickup;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o, meas_strobe, pickup, stage_start, stage_trip, stage_blocked;
  logic line_neutral_connected = 1'b1;
  logic third_residual_mode = 1'b0;
  logic fourth_residual_mode = 1'b0;
  logic stage_forcing_enable = 1'b0;
  logic block_in = 1'b0;
  logic [15:0] want [6] = '{default: 16'h0000};
  logic [15:0] mag [6];
  logic [2:0] v;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  nov_stage #(.TICK_CYCLES(20)) uut (
    .clk_sys, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .residual_voltage(mag[0]), .third_voltage_channel(mag[1]),
    .fourth_voltage_channel(mag[2]), .phase1_voltage(mag[3]),
    .phase2_voltage(mag[4]), .phase3_voltage(mag[5]),
    .meas_strobe, .line_neutral_connected, .third_residual_mode,
    .fourth_residual_mode, .stage_forcing_enable, .block_in,
    .pickup, .stage_start, .stage_trip, .stage_blocked
  );
  nov_front #(.PERIOD(1250)) u_front (.clk_sys, .sys_rst, .want, .mag, .meas_strobe);
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    check(n < 20, 1'b1);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task automatic src(input logic [1:0] e);
    repeat (2) @(posedge clk_sys);
    wb(1'b0, `NOV_OFS_STATUS, 32'h0);
    check(rd[1:0], e);
  endtask
  task automatic lvl(input logic [15:0] val, input logic e);
    int n;
    n = 0;
    want[1] <= val;
    @(posedge clk_sys);
    do begin
      @(posedge clk_sys);
      n++;
    end while (meas_strobe !== 1'b1 && n < 2000);
    repeat (4) @(posedge clk_sys);
    check(pickup, e);
  endtask
  task automatic t_regs();
    rdc(`NOV_OFS_CTRL, 32'h0);
    rdc(`NOV_OFS_VT_NOM, 32'h3E8);
    rdc(`NOV_OFS_GRP0 + 8'h04, 32'h8);
    rdc(`NOV_OFS_GRP0 + 8'h08, 32'h5);
    rdc(`NOV_OFS_GRP0 + 8'h0C, 32'h64);
    rdc(`NOV_OFS_PICKUP_PRI, 32'hC8);
    rdc(8'h60, 32'h0);
    wb(1'b1, `NOV_OFS_GRP0, 32'h63);
    rdc(`NOV_OFS_GRP0, 32'h7D0);
    wb(1'b1, `NOV_OFS_GRP0, 32'h26AD);
    rdc(`NOV_OFS_GRP0, 32'h7D0);
    wb(1'b1, `NOV_OFS_GRP0, 32'h64);
    rdc(`NOV_OFS_PICKUP_PRI, 32'hA);
    wb(1'b1, `NOV_OFS_GRP0, 32'h7D0);
    $display("t_regs done");
  endtask
  task automatic t_src();
    src(2'h1);
    line_neutral_connected <= 1'b0;
    src(2'h0);
    wb(1'b1, `NOV_OFS_CTRL, 32'h2);
    src(2'h0);
    third_residual_mode <= 1'b1;
    fourth_residual_mode <= 1'b1;
    for (int s = 1; s < 4; s++) begin
      wb(1'b1, `NOV_OFS_CTRL, 32'(s));
      src(s[1:0]);
    end
    line_neutral_connected <= 1'b1;
    $display("t_src done");
  endtask
  task automatic t_pick();
    int n;
    n = 0;
    wb(1'b1, `NOV_OFS_CTRL, 32'h2);
    lvl(16'h07D0, 1'b1);
    check(stage_start, 1'b1);
    while (stage_trip !== 1'b1 && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    check(n >= 125 && n <= 175, 1'b1);
    rdc(`NOV_OFS_EXPECTED, 32'h8);
    lvl(16'h0474, 1'b1);
    lvl(16'h03E8, 1'b0);
    check(stage_trip, 1'b0);
    wb(1'b1, `NOV_OFS_GRP0 + 8'h04, 32'h0);
    lvl(16'h07D0, 1'b1);
    check({stage_start, stage_trip}, 2'h3);
    lvl(16'h03E8, 1'b0);
    wb(1'b1, `NOV_OFS_GRP0 + 8'h04, 32'h8);
    $display("t_pick done");
  endtask
  task automatic t_calc();
    wb(1'b1, `NOV_OFS_CTRL, 32'h1);
    want[5] <= 16'h2328;
    lvl(16'h0000, 1'b1);
    want[5] <= 16'h0BB8;
    lvl(16'h0000, 1'b0);
    want[5] <= 16'h0000;
    $display("t_calc done");
  endtask
  task automatic t_block();
    wb(1'b1, `NOV_OFS_CTRL, 32'h2);
    block_in <= 1'b1;
    lvl(16'h07D0, 1'b1);
    check({stage_blocked, stage_start}, 2'h2);
    block_in <= 1'b0;
    lvl(16'h03E8, 1'b0);
    $display("t_block done");
  endtask
  task automatic t_force();
    wb(1'b1, `NOV_OFS_CTRL, 32'h8);
    @(posedge clk_sys);
    check(stage_trip, 1'b0);
    stage_forcing_enable <= 1'b1;
    for (int f = 0; f < 4; f++) begin
      wb(1'b1, `NOV_OFS_CTRL, 32'(f << 2));
      @(posedge clk_sys);
      v = {stage_blocked, stage_trip, stage_start};
      if (f == 0) check(v, 3'h0);
      else check(v[f - 1], 1'b1);
    end
    stage_forcing_enable <= 1'b0;
    $display("t_force done");
  endtask
  task automatic t_group();
    wb(1'b1, `NOV_OFS_GRP1, 32'h2328);
    wb(1'b1, `NOV_OFS_CTRL, 32'h22);
    lvl(16'h07D0, 1'b0);
    src(2'h2);
    wb(1'b1, `NOV_OFS_CTRL, 32'h2);
    lvl(16'h07D0, 1'b1);
    lvl(16'h03E8, 1'b0);
    $display("t_group done");
  endtask
  task automatic t_inverse_time_mode();
    wb(1'b1, `NOV_OFS_CTRL, 32'h12);
    lvl(16'h07D0, 1'b1);
    repeat (120) @(posedge clk_sys);
    rdc(`NOV_OFS_RATIO, 32'hAD);
    rdc(`NOV_OFS_EXPECTED, 32'hD);
    repeat (200) @(posedge clk_sys);
    check(stage_trip, 1'b1);
    wb(1'b0, `NOV_OFS_REMAINING, 32'h0);
    check(rd[31], 1'b1);
    lvl(16'h03E8, 1'b0);
    wb(1'b1, `NOV_OFS_CTRL, 32'h2);
    rdc(`NOV_OFS_REMAINING, 32'h8);
    $display("t_inverse_time_mode done");
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs();
    t_src();
    t_pick();
    t_calc();
    t_block();
    t_force();
    t_group();
    t_inverse_time_mode();
    stop_test();
  end
endmodule // tb_neutral_overvoltage_pickup
`default_nettype wire
